// ### sadc_core_model.sv
// sadc_core_model.sv: behavioural analog core answering both converter units
module sadc_core_model (
  input  wire logic            clk,
  input  wire logic [1:0]      core_start,
  input  wire logic [1:0][2:0] core_chan,
  output logic [1:0]           core_done,
  output logic [1:0][9:0]      core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0][3:0] dly;

  initial begin
    dly = '0;
    core_done = '0;
    core_result = '0;
  end

  // done comes five cycles after each start; result encodes unit and channel
  always @(posedge clk) begin
    for (int u = 0; u < 2; u++) begin
      core_done[u] <= 1'b0;
      core_result[u] <= ~core_result[u]; // result only valid with done
      if (core_start[u]) begin
        dly[u] <= 4'h5;
      end else if (dly[u] != 4'h0) begin
        dly[u] <= dly[u] - 4'h1;
      end
      if (!core_start[u] && dly[u] == 4'h1) begin
        core_done[u] <= 1'b1;
        core_result[u] <= {u[0], core_chan[u], 6'h2A};
      end
    end
  end
endmodule

// ### sadc_defs.svh
// sadc_defs.svh: register offsets, field positions, reset values and conversion counts
//------------------------------------------------------------
// Summary of operation
// RULE1: eight read-only 16-bit results per unit, 10-bit value in 15:6, low six zero
// RULE2: software reads result registers only as whole words, never bytes
// RULE3: result of input n lands in result register n
// RULE4: end flag bit 7 sets after a single conversion or after a full scan
// RULE5: end flag clears on a write of 0 only after it was read as 1
// RULE6: transfer controller reading a result clears the end flag; code clears it only while enable bit 6 is set
// RULE7: interrupt request is high while end flag and enable bit 6 are set
// RULE8: start bit 5 written 1 starts; written 0 stops and idles the converter
// RULE9: single mode clears the start bit when its conversion completes
// RULE10: scan mode keeps converting until start is cleared or reset
// RULE11: status bit 4 and config bits 1:0 read zero and ignore writes
// RULE12: single mode channel select 0..7 picks input 0..7; top bit prohibited
// RULE13: four-channel scan covers group base 0 or 4 plus low bits count
// RULE14: eight-channel scan covers input 0 up to the selected input
// RULE15: trigger select 00 off, 01 timer unit, 11 external pin, 10 prohibited
// RULE16: mode bits 0X single, 10 scan of four, 11 scan of eight
// RULE17: conversion length 530, 266, 134 or 68 states by clock select
// RULE18: software changes clock select only while start bit is 0
// RULE19: each pull-down bit enables the matching input pull-down, reset 0
// RULE20: two identical units, second unit inputs 8..15 map like 0..7
// RULE21: each unit has its own external trigger input
// RULE22: falling edge on external trigger with select 11 sets the start bit
// RULE23: scan restarts at the group's first channel after the end or a stop
// RULE24: scan conversions after the first take 512, 256, 128 or 64 states
// RULE25: control drives core channel and start, captures result on completion
// RULE26: software write beats hardware start clear; hardware flag set beats clear
//------------------------------------------------------------
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// register byte offsets, unit 1 sits one stride above unit 0
`define SADC_UNIT_STRIDE  8'h40
`define SADC_OFS_CSR      8'h20
`define SADC_OFS_CFG      8'h24
`define SADC_OFS_PULLDOWN 8'h80

// field positions
`define SADC_CSR_FLAG   7
`define SADC_CSR_IRQEN  6
`define SADC_CSR_START  5
`define SADC_CFG_SCAN_ENABLE  5
`define SADC_CFG_SCAN_SIZE  4

// reset values
`define SADC_CSR_RST 8'h00
`define SADC_CFG_RST 8'h00
`define SADC_PD_RST  16'h0000

// trigger select codes
`define SADC_TRG_OFF   2'h0
`define SADC_TRG_TIMER 2'h1
`define SADC_TRG_EXT   2'h3

// bus responses
`define SADC_RESP_OK  2'h0
`define SADC_RESP_ERR 2'h2

// first conversion length in states: 530, 266, 134, 68
`define SADC_T1_CONV_CLOCK_SELECT_LO 10'h212
`define SADC_T1_CONV_CLOCK_SELECT_HI 10'h10A
`define SADC_T1_CKS2 10'h086
`define SADC_T1_CKS3 10'h044
// later scan conversions in states: 512, 256, 128, 64
`define SADC_TN_CONV_CLOCK_SELECT_LO 10'h200
`define SADC_TN_CONV_CLOCK_SELECT_HI 10'h100
`define SADC_TN_CKS2 10'h080
`define SADC_TN_CKS3 10'h040

`endif

// ### sadc_fall.sv
// sadc_fall.sv: falling edge detector for an active-low trigger pin
module sadc_fall (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_b,
  output logic      fall
);
  import sadc_pkg::*;

  sadc_fall_t s;
  sadc_fall_t n;

  // remember the previous pin level
  always_comb begin
    n.prev = pin_b;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s.prev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign fall = s.prev & ~pin_b; // [RULE22]
endmodule

// ### sadc_pkg.sv
// sadc_pkg.sv: types shared by the converter control blocks
package sadc_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_CONV = 3'h2,
    SEQ_HALT = 3'h4
  } sadc_seq_st_t;

  typedef struct packed {
    sadc_seq_st_t st;
    logic [2:0]   ch;
    logic         first;
    logic         seen;
    logic [9:0]   cnt;
    logic         start_p;
    logic         res_we;
    logic [2:0]   res_ch;
    logic [9:0]   res_data;
    logic         end_evt;
    logic         single_done;
  } sadc_seq_t;

  typedef struct packed {
    logic prev;
  } sadc_fall_t;

  typedef struct packed {
    logic            flag;
    logic            irq_en;
    logic            start;
    logic            armed;
    logic            kick;
    logic [3:0]      chsel;
    logic [1:0]      trg;
    logic            scan_e;
    logic            scan_s;
    logic [1:0]      cks;
    logic [7:0][9:0] res;
  } sadc_unit_t;

  typedef struct packed {
    logic       ok;
    logic       unit;
    logic       is_res;
    logic       is_csr;
    logic       is_cfg;
    logic       is_pd;
    logic [2:0] idx;
  } sadc_dec_t;

  typedef struct packed {
    sadc_unit_t [1:0] u;
    logic [15:0]      pd;
    logic             aw_hold;
    logic             w_hold;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sadc_top_t;

endpackage

// ### sadc_seq.sv
// sadc_seq.sv: channel sequencer and conversion timer of one unit
`include "sadc_defs.svh"
module sadc_seq (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       kick,
  input  wire logic       scan_e,
  input  wire logic       scan_s,
  input  wire logic [2:0] chsel,
  input  wire logic [1:0] cks,
  input  wire logic       core_done,
  input  wire logic [9:0] core_result,
  output logic            core_start,
  output logic [2:0]      core_chan,
  output logic            res_we,
  output logic [2:0]      res_ch,
  output logic [9:0]      res_data,
  output logic            end_evt,
  output logic            single_done
);
  import sadc_pkg::*;

  sadc_seq_t  s;
  sadc_seq_t  n;
  logic [2:0] first_ch;
  logic       go;

  // conversion length minus one
  function automatic logic [9:0] conv_len(input logic first, input logic [1:0] sel);
    logic [9:0] v;
    case (sel)
      2'h0: v = first ? `SADC_T1_CONV_CLOCK_SELECT_LO : `SADC_TN_CONV_CLOCK_SELECT_LO;
      2'h1: v = first ? `SADC_T1_CONV_CLOCK_SELECT_HI : `SADC_TN_CONV_CLOCK_SELECT_HI;
      2'h2: v = first ? `SADC_T1_CKS2 : `SADC_TN_CKS2;
      default: v = first ? `SADC_T1_CKS3 : `SADC_TN_CKS3;
    endcase
    return v - 10'h001;
  endfunction

  // group start; the group end is always the selected channel
  assign first_ch = scan_e ? (scan_s ? 3'h0 : {chsel[2], 2'h0}) : chsel; // [RULE12] [RULE13] [RULE14] [RULE16]
  assign go = run & ((s.st == SEQ_IDLE) | ((s.st == SEQ_HALT) & kick));

  // next state
  always_comb begin
    n = s;
    n.start_p = 1'b0;
    n.res_we = 1'b0;
    n.end_evt = 1'b0;
    n.single_done = 1'b0;
    case (s.st)
      SEQ_CONV: begin
        if (core_done) begin
          n.seen = 1'b1;
          n.res_data = core_result; // result only stands with done
        end
        if (s.cnt != 10'h000) begin
          n.cnt = s.cnt - 10'h001; // [RULE17] [RULE24]
        end else if (s.seen || core_done) begin
          n.res_we = 1'b1; // [RULE25]
          n.res_ch = s.ch;
          n.seen = 1'b0;
          n.first = 1'b0;
          n.start_p = 1'b1;
          n.cnt = conv_len(1'b0, cks);
          if (s.ch != chsel) begin
            n.ch = s.ch + 3'h1;
          end else begin
            n.end_evt = 1'b1; // [RULE4]
            n.ch = first_ch; // [RULE23]
            if (!scan_e) begin
              n.st = SEQ_HALT; // [RULE9]
              n.single_done = 1'b1;
              n.start_p = 1'b0;
            end
          end
        end
      end
      SEQ_IDLE, SEQ_HALT: begin
      end
      default: n.st = SEQ_IDLE;
    endcase
    // (re)start at the group's first channel
    if (go) begin
      n.st = SEQ_CONV;
      n.ch = first_ch; // [RULE23]
      n.first = 1'b1;
      n.seen = 1'b0;
      n.cnt = conv_len(1'b1, cks);
      n.start_p = 1'b1; // [RULE25]
    end
    // a cleared start bit stops everything at once
    if (!run) begin
      n.st = SEQ_IDLE; // [RULE8] [RULE10]
      n.start_p = 1'b0;
      n.res_we = 1'b0;
      n.end_evt = 1'b0;
      n.single_done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= SEQ_IDLE;
    end else begin
      s <= n;
    end
  end

  assign core_start = s.start_p;
  assign core_chan = s.ch;
  assign res_we = s.res_we;
  assign res_ch = s.res_ch;
  assign res_data = s.res_data;
  assign end_evt = s.end_evt;
  assign single_done = s.single_done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SEQ_CHAN: assert property ( // [RULE13]
    core_start |-> core_chan >= first_ch && core_chan <= chsel
  ) else $error("core started outside the selected group");

  AST_SEQ_LEN: assert property ( // [RULE17]
    s.st == SEQ_CONV && s.cnt != 10'h000 && run |=> !res_we
  ) else $error("result captured before conversion time");

  AST_SEQ_WRAP: assert property ( // [RULE23]
    end_evt && scan_e && run && !kick |-> core_start && core_chan == first_ch
  ) else $error("scan did not restart at first channel");
endmodule

// ### sadc_top.sv
// sadc_top.sv: two converter units with their register file on an AXI4-Lite slave
`include "sadc_defs.svh"
module sadc_top (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             xfer_ctrl_read,
  input  wire logic             ext_conv_trigger_u0_b,
  input  wire logic             ext_conv_trigger_u1_b,
  input  wire logic [1:0]       timer_unit_trigger,
  output logic [1:0]            core_start,
  output logic [1:0][2:0]       core_chan,
  input  wire logic [1:0]       core_done,
  input  wire logic [1:0][9:0]  core_result,
  output logic [1:0]            conv_end_irq,
  output logic [15:0]           pulldown_ch
);
  import sadc_pkg::*;

  sadc_top_t       s;
  sadc_top_t       n;
  sadc_dec_t       wd;
  sadc_dec_t       rd;
  logic            aw_fire;
  logic            w_fire;
  logic            ar_fire;
  logic            wr_go;
  logic [1:0]      sw_csr;
  logic [1:0]      trig_b;
  logic [1:0]      trig_fall;
  logic [1:0]      seq_res_we;
  logic [1:0][2:0] seq_res_ch;
  logic [1:0][9:0] seq_res_data;
  logic [1:0]      seq_end;
  logic [1:0]      seq_sdone;

  //------------------------------------------------------------
  // address decode
  //------------------------------------------------------------

  // map a byte address onto unit, register kind and result index
  function automatic sadc_dec_t sadc_decode(input logic [7:0] a);
    sadc_dec_t  d;
    logic [7:0] lo;
    d = '0;
    lo = {2'h0, a[5:0]};
    if (a[1:0] == 2'h0) begin
      if (a == `SADC_OFS_PULLDOWN) begin
        d.ok = 1'b1;
        d.is_pd = 1'b1;
      end else if (a < (`SADC_UNIT_STRIDE << 1)) begin
        d.unit = a[6];
        d.idx = lo[4:2];
        d.is_res = lo < `SADC_OFS_CSR;
        d.is_csr = lo == `SADC_OFS_CSR;
        d.is_cfg = lo == `SADC_OFS_CFG;
        d.ok = d.is_res | d.is_csr | d.is_cfg;
      end
    end
    return d;
  endfunction

  // status byte image with reserved bit 4 reading zero
  function automatic logic [7:0] csr_img(input sadc_unit_t x);
    return {x.flag, x.irq_en, x.start, 1'b0, x.chsel}; // [RULE11]
  endfunction

  // handshakes: one write and one read in flight at a time
  assign s_axi_awready = ~s.aw_hold & ~s.bvalid;
  assign s_axi_wready = ~s.w_hold & ~s.bvalid;
  assign s_axi_arready = ~s.rvalid;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wr_go = s.aw_hold & s.w_hold;
  assign wd = sadc_decode(s.awaddr);
  assign rd = sadc_decode(s_axi_araddr);

  //------------------------------------------------------------
  // converter units
  //------------------------------------------------------------

  assign trig_b = {ext_conv_trigger_u1_b, ext_conv_trigger_u0_b};

  // two identical units, each with its own trigger pin
  for (genvar g = 0; g < 2; g++) begin : g_unit // [RULE20] [RULE21]
    sadc_fall u_fall (
      .clk   (clk),
      .rst_b (rst_b),
      .pin_b (trig_b[g]),
      .fall  (trig_fall[g])
    );

    sadc_seq u_seq (
      .clk         (clk),
      .rst_b       (rst_b),
      .run         (s.u[g].start),
      .kick        (s.u[g].kick),
      .scan_e      (s.u[g].scan_e),
      .scan_s      (s.u[g].scan_s),
      .chsel       (s.u[g].chsel[2:0]),
      .cks         (s.u[g].cks),
      .core_done   (core_done[g]),
      .core_result (core_result[g]),
      .core_start  (core_start[g]),
      .core_chan   (core_chan[g]),
      .res_we      (seq_res_we[g]),
      .res_ch      (seq_res_ch[g]),
      .res_data    (seq_res_data[g]),
      .end_evt     (seq_end[g]),
      .single_done (seq_sdone[g])
    );
  end

  //------------------------------------------------------------
  // register file and bus state
  //------------------------------------------------------------

  // next state: bus capture, software access, then hardware events
  always_comb begin
    logic wsel;
    logic rsel;
    logic hw_trig;
    wsel = 1'b0;
    rsel = 1'b0;
    hw_trig = 1'b0;
    n = s;
    sw_csr = 2'h0;
    if (aw_fire) begin
      n.aw_hold = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      n.w_hold = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    // write: both halves held, answer next edge
    if (wr_go) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wd.ok ? `SADC_RESP_OK : `SADC_RESP_ERR;
      if (wd.is_pd && s.wstrb[0]) begin
        n.pd[7:0] = s.wdata[7:0]; // [RULE19]
      end
      if (wd.is_pd && s.wstrb[1]) begin
        n.pd[15:8] = s.wdata[15:8]; // [RULE19]
      end
    end
    // read: data stands until rready
    if (ar_fire) begin
      n.rvalid = 1'b1;
      n.rresp = rd.ok ? `SADC_RESP_OK : `SADC_RESP_ERR;
      n.rdata = rd.is_pd ? {16'h0000, s.pd} : 32'h0000_0000;
    end
    for (int i = 0; i < 2; i++) begin
      wsel = wr_go && wd.ok && (wd.unit == 1'(i)) && s.wstrb[0];
      rsel = ar_fire && rd.ok && (rd.unit == 1'(i));
      n.u[i].kick = 1'b0;
      if (rsel && rd.is_res) begin
        n.rdata = {16'h0000, s.u[i].res[rd.idx], 6'h00}; // [RULE1]
      end
      if (rsel && rd.is_cfg) begin
        n.rdata = {24'h00_0000, s.u[i].trg, s.u[i].scan_e, s.u[i].scan_s, s.u[i].cks, 2'h0}; // [RULE11]
      end
      if (rsel && rd.is_csr) begin
        n.rdata = {24'h00_0000, csr_img(s.u[i])};
        if (s.u[i].flag) begin
          n.u[i].armed = 1'b1; // [RULE5]
        end
      end
      // transfer controller fetching a result with the interrupt enabled acknowledges the end
      if (rsel && rd.is_res && xfer_ctrl_read && s.u[i].irq_en && s.u[i].flag) begin
        n.u[i].flag = 1'b0; // [RULE6]
        n.u[i].armed = 1'b0;
      end
      if (wsel && wd.is_cfg) begin
        n.u[i].trg = s.wdata[7:6]; // [RULE15]
        n.u[i].scan_e = s.wdata[`SADC_CFG_SCAN_ENABLE]; // [RULE16]
        n.u[i].scan_s = s.wdata[`SADC_CFG_SCAN_SIZE];
        n.u[i].cks = s.wdata[3:2]; // [RULE17]
      end
      if (wsel && wd.is_csr) begin
        sw_csr[i] = 1'b1;
        if (!s.wdata[`SADC_CSR_FLAG] && s.u[i].armed) begin
          n.u[i].flag = 1'b0; // [RULE5]
          n.u[i].armed = 1'b0;
        end
        n.u[i].irq_en = s.wdata[`SADC_CSR_IRQEN];
        n.u[i].start = s.wdata[`SADC_CSR_START]; // [RULE8]
        n.u[i].kick = s.wdata[`SADC_CSR_START];
        n.u[i].chsel = s.wdata[3:0]; // [RULE12]
      end
      // hardware start sources, software write wins
      hw_trig = ((s.u[i].trg == `SADC_TRG_TIMER) && timer_unit_trigger[i]) ||
                ((s.u[i].trg == `SADC_TRG_EXT) && trig_fall[i]); // [RULE15] [RULE22]
      if (hw_trig && !s.u[i].start && !sw_csr[i]) begin
        n.u[i].start = 1'b1; // [RULE22]
        n.u[i].kick = 1'b1;
      end
      if (seq_sdone[i] && !sw_csr[i]) begin
        n.u[i].start = 1'b0; // [RULE9] [RULE26]
      end
      if (seq_res_we[i]) begin
        n.u[i].res[seq_res_ch[i]] = seq_res_data[i]; // [RULE3]
      end
      if (seq_end[i]) begin
        n.u[i].flag = 1'b1; // [RULE4] [RULE26]
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
      s.pd <= `SADC_PD_RST;
    end else begin
      s <= n;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pulldown_ch = s.pd;
  assign conv_end_irq[0] = s.u[0].flag & s.u[0].irq_en; // [RULE7]
  assign conv_end_irq[1] = s.u[1].flag & s.u[1].irq_en; // [RULE7]

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RESULT_LOW_ZERO: assert property ( // [RULE1]
    ar_fire && rd.ok && rd.is_res |=> s_axi_rvalid && s_axi_rdata[5:0] == 6'h00 && s_axi_rdata[31:16] == 16'h0000
  ) else $error("result read shows nonzero low or upper bits");

  AST_RESULT_CHANNEL: assert property ( // [RULE3]
    seq_res_we[0] |=> s.u[0].res[$past(seq_res_ch[0])] == $past(seq_res_data[0])
  ) else $error("result stored in the wrong register");

  AST_FLAG_SET: assert property ( // [RULE4]
    seq_end[1] |=> s.u[1].flag
  ) else $error("end flag not set after conversion end");

  AST_FLAG_WRITE_ONE: assert property ( // [RULE5]
    sw_csr[0] && s.wdata[7] && s.u[0].flag |=> s.u[0].flag
  ) else $error("write of one cleared the end flag");

  AST_FLAG_UNREAD: assert property ( // [RULE5]
    sw_csr[0] && !s.u[0].armed && s.u[0].flag |=> s.u[0].flag
  ) else $error("end flag cleared without a prior read");

  AST_FLAG_XFER: assert property ( // [RULE6]
    ar_fire && rd.ok && rd.is_res && !rd.unit && xfer_ctrl_read && conv_end_irq[0] && !seq_end[0] |=> !s.u[0].flag
  ) else $error("transfer controller read left the end flag set");

  AST_IRQ: assert property ( // [RULE7]
    seq_end[0] && s.u[0].irq_en && !sw_csr[0] |=> conv_end_irq[0]
  ) else $error("interrupt request missing after conversion end");

  AST_STOP: assert property ( // [RULE8]
    !s.u[0].start |=> !core_start[0]
  ) else $error("core started while start bit clear");

  AST_SINGLE_CLEAR: assert property ( // [RULE9]
    seq_sdone[0] && !sw_csr[0] |=> !s.u[0].start
  ) else $error("single mode did not clear start bit");

  AST_SCAN_HOLD: assert property ( // [RULE10]
    seq_end[0] && s.u[0].scan_e && !sw_csr[0] |=> s.u[0].start
  ) else $error("scan mode dropped the start bit");

  AST_CFG_RESERVED: assert property ( // [RULE11]
    ar_fire && rd.ok && (rd.is_cfg || rd.is_csr) |=> ($past(rd.is_cfg) ? s_axi_rdata[1:0] == 2'h0 : !s_axi_rdata[4])
  ) else $error("reserved bits read nonzero");

  AST_TRIG_OFF: assert property ( // [RULE15]
    s.u[0].trg == `SADC_TRG_OFF && !s.u[0].start && !sw_csr[0] |=> !s.u[0].start
  ) else $error("hardware start while triggers disabled");

  AST_EXT_TRIG: assert property ( // [RULE22]
    s.u[0].trg == `SADC_TRG_EXT && trig_fall[0] && !s.u[0].start && !sw_csr[0] |=> s.u[0].start ##1 core_start[0]
  ) else $error("external trigger edge did not start conversion");

  AST_PULLDOWN: assert property ( // [RULE19]
    wr_go && wd.ok && wd.is_pd && s.wstrb[1] |=> pulldown_ch[15:8] == $past(s.wdata[15:8])
  ) else $error("pull-down enables not updated");

  COV_SINGLE_DONE: cover property (seq_sdone[0] ##1 !s.u[0].start);
  COV_SCAN_WRAP: cover property (seq_end[1] && s.u[1].scan_e ##1 core_start[1]);
  COV_EXT_START: cover property (trig_fall[0] && s.u[0].trg == `SADC_TRG_EXT ##2 core_start[0]);
  COV_XFER_CLEAR: cover property (ar_fire && rd.is_res && xfer_ctrl_read && conv_end_irq[0]);
endmodule

// ### tb_sadc_top.sv
// tb_sadc_top.sv: self-checking bench for the converter control block
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_sadc_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} sadc_tb_row_t;
  logic clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, xfer = 1'b0, t0_b = 1'b1, t1_b = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, cstart, cdone, irq, r, tim = 2'h0;
  logic [1:0][2:0] cchan;
  logic [1:0][9:0] cres;
  logic [15:0] pd;
  int checks = 0, n_mismatch = 0, k1, k2;
  sadc_tb_row_t rows [9] = '{{8'h20, 1'b0, 32'h0, 32'h0, 2'h0}, {8'h24, 1'b0, 32'h0, 32'h0, 2'h0},
    {8'h80, 1'b0, 32'h0, 32'h0, 2'h0}, {8'h80, 1'b1, 32'hFFFFA5C3, 32'hA5C3, 2'h0},
    {8'h24, 1'b1, 32'hFF, 32'hFC, 2'h0}, {8'h20, 1'b1, 32'h57, 32'h47, 2'h0},
    {8'h20, 1'b1, 32'h0, 32'h0, 2'h0}, {8'h64, 1'b1, 32'h0F, 32'h0C, 2'h0}, {8'h30, 1'b1, 32'h1, 32'h0, 2'h2}};

  sadc_top u_sadc_top (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xfer_ctrl_read(xfer),
    .ext_conv_trigger_u0_b(t0_b), .ext_conv_trigger_u1_b(t1_b), .timer_unit_trigger(tim),
    .core_start(cstart), .core_chan(cchan), .core_done(cdone), .core_result(cres),
    .conv_end_irq(irq), .pulldown_ch(pd));
  sadc_core_model u_sadc_core_model (.clk(clk), .core_start(cstart), .core_chan(cchan),
    .core_done(cdone), .core_result(cres));

  // free-running 20 MHz clock
  always #25 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    end_of_test();
  endtask
  // write address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50 && (k == 0 || awvalid || wvalid || bready); k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (k >= 50) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && (k == 0 || arvalid || rready); k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (k >= 50) hang();
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    `CHK(n, e, d)
  endtask
  // waits for the next core start of unit u and checks its channel
  task automatic wst(input int u, input logic [2:0] ch, output int k);
    for (k = 0; k < 400 && cstart[u] !== 1'b1; k++) @(posedge clk);
    if (k >= 400) hang();
    `CHK("core_chan", ch, cchan[u])
    @(posedge clk);
  endtask
  task automatic wirq(input int u);
    int k;
    for (k = 0; k < 400 && irq[u] !== 1'b1; k++) @(posedge clk);
    if (k >= 400) hang();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // register table rows: reset values, reserved bits, unmapped place
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        `CHK("bresp", rows[i].r, r)
      end
      chk(rows[i].a, rows[i].e, "reg_read");
      `CHK("rresp", rows[i].r, r)
    end
    `CHK("pulldown_ch", 16'hA5C3, pd)
    $display("test registers done");
    wr(8'h24, 32'h0C);
    wr(8'h20, 32'h65);
    wst(0, 3'd5, k1);
    wirq(0);
    wr(8'h20, 32'h45);
    chk(8'h20, 32'hC5, "csr_single");
    chk(8'h14, {16'h0, 1'b0, 3'd5, 6'h2A, 6'h0}, "result_ch5");
    wr(8'h20, 32'h45);
    chk(8'h20, 32'h45, "csr_clear");
    `CHK("irq_low", 1'b0, irq[0])
    $display("test single done");
    wr(8'h64, 32'h2C);
    wr(8'h60, 32'h26);
    foreach (rows[i]) if (i < 4) wst(1, 3'd4 + 3'(i % 3), k1);
    wr(8'h60, 32'h06);
    chk(8'h60, 32'h86, "csr_scan");
    `CHK("irq_u1_off", 1'b0, irq[1])
    k2 = 0;
    repeat (200) begin
      @(posedge clk);
      k2 += int'(cstart[1]);
    end
    `CHK("starts_after_stop", 0, k2)
    chk(8'h58, {16'h0, 1'b1, 3'd6, 6'h2A, 6'h0}, "result_u1_ch6");
    wr(8'h24, 32'h3C);
    wr(8'h20, 32'h22);
    wst(0, 3'd0, k1);
    wst(0, 3'd1, k1);
    wst(0, 3'd2, k2);
    `CHK("interval_diff", 4, k1 - k2)
    wst(0, 3'd0, k1);
    wr(8'h20, 32'h02);
    chk(8'h20, 32'h82, "csr_scan8");
    wr(8'h20, 32'h42);
    $display("test scan done");
    // external, timer and no trigger source, config rewritten while stopped with clock select kept at 3
    for (int i = 0; i < 3; i++) begin
      wr(8'h24, i == 0 ? 32'hCC : (i == 1 ? 32'h4C : 32'h0C));
      tim <= {1'b0, i != 0};
      t0_b <= (i == 1);
      @(posedge clk);
      tim <= 2'h0;
      t0_b <= 1'b1;
      if (i == 2) begin
        k2 = 0;
        repeat (60) begin
          @(posedge clk);
          k2 += int'(cstart[0]);
        end
        `CHK("no_trigger", 0, k2)
      end else begin
        wst(0, 3'd2, k1);
        wirq(0);
        xfer <= 1'b1;
        chk(8'h08, {16'h0, 1'b0, 3'd2, 6'h2A, 6'h0}, "xfer_result");
        xfer <= 1'b0;
        `CHK("irq_after_xfer", 1'b0, irq[0])
      end
    end
    $display("test triggers done");
    // reset in the middle of a conversion
    wr(8'h20, 32'h62);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK("pd_reset", 16'h0000, pd)
    chk(8'h20, 32'h0, "csr_reset");
    $display("test reset done");
    end_of_test();
  end
endmodule
